// ### include/serial_frame_defs.vh
// Constants shared by the serial frame transmitter files
`ifndef SERIAL_FRAME_DEFS_VH
`define SERIAL_FRAME_DEFS_VH

// ********************************
// Code group bytes
// ********************************
`define SFT_K28_5 8'hbc
`define SFT_K28_7 8'hfc
`define SFT_D28_7 8'hfc
`define SFT_D5_6 8'hc5
`define SFT_D16_2 8'h50

// ********************************
// Frame layout and timing
// ********************************
`define SFT_GROUP_BITS 4'h9
`define SFT_SYNC_EDGES 2'h2
`define SFT_SCR_SEED 15'h7fff
`define SFT_DITHER_SEED 23'h000001
`define SFT_SAMPLE_W 16
`define SFT_FIFO_DEPTH 8

// ********************************
// Rate range codes, one-hot
// ********************************
`define SFT_RANGE_LOW 3'h1
`define SFT_RANGE_MID 3'h2
`define SFT_RANGE_HIGH 3'h4

`endif

// ### core/sample_fifo.v
// Sample FIFO with registered read stage and registered ready
`timescale 1ns/1ps
`default_nettype none
module sample_fifo #(
	parameter WIDTH = 16,
	parameter DEPTH = 8,
	parameter AW = 3
) (
	input wire clk,
	input wire rst_n,
	input wire in_valid,
	output wire in_ready,
	input wire [WIDTH-1:0] in_data,
	output wire out_valid,
	input wire out_ready,
	output wire [WIDTH-1:0] out_data
);
	reg [WIDTH-1:0] mem [0:DEPTH-1];
	reg [AW-1:0] wr_ptr_q;
	reg [AW-1:0] rd_ptr_q;
	reg [AW:0] count_q;
	reg [AW:0] count_d;
	reg ready_q;
	reg out_valid_q;
	reg [WIDTH-1:0] out_data_q;
	wire push;
	wire pop;

	assign push = in_valid && ready_q;
	// Refill the output stage from memory whenever it is free or drained
	assign pop = (count_q != {(AW+1){1'b0}}) && (!out_valid_q || out_ready);
	assign in_ready = ready_q;
	assign out_valid = out_valid_q;
	assign out_data = out_data_q;

	always @* begin
		count_d = count_q;
		if (push && !pop)
			count_d = count_q + 1'b1;
		else if (pop && !push)
			count_d = count_q - 1'b1;
	end

	always @(posedge clk) begin
		if (push)
			mem[wr_ptr_q] <= in_data;
	end

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			wr_ptr_q <= {AW{1'b0}};
			rd_ptr_q <= {AW{1'b0}};
			count_q <= {(AW+1){1'b0}};
			ready_q <= 1'b0;
			out_valid_q <= 1'b0;
			out_data_q <= {WIDTH{1'b0}};
		end else begin
			count_q <= count_d;
			// Ready from next count, so a full FIFO never takes a word
			ready_q <= (count_d < DEPTH);
			if (push)
				wr_ptr_q <= wr_ptr_q + 1'b1;
			if (pop) begin
				rd_ptr_q <= rd_ptr_q + 1'b1;
				out_data_q <= mem[rd_ptr_q];
				out_valid_q <= 1'b1;
			end else if (out_ready)
				out_valid_q <= 1'b0;
		end
	end
endmodule // sample_fifo
`default_nettype wire

// ### core/code_group_encoder.v
// Combinational 8b/10b code group encoder with running disparity
`timescale 1ns/1ps
`default_nettype none
module code_group_encoder (
	input wire [7:0] data_byte,
	input wire ctrl,
	input wire rd_in,
	output wire [9:0] code,
	output wire rd_out
);
	reg [5:0] six;
	reg [3:0] four;
	reg [5:0] six_neg;
	reg [3:0] four_neg;
	reg rd6;
	reg unbal6;
	reg alt7;
	wire [4:0] x;
	wire [2:0] y;

	assign x = data_byte[4:0];
	assign y = data_byte[7:5];

	always @* begin
		six_neg = 6'h00;
		four_neg = 4'h0;
		case (x)
			5'd0: six_neg = 6'b100111;
			5'd1: six_neg = 6'b011101;
			5'd2: six_neg = 6'b101101;
			5'd3: six_neg = 6'b110001;
			5'd4: six_neg = 6'b110101;
			5'd5: six_neg = 6'b101001;
			5'd6: six_neg = 6'b011001;
			5'd7: six_neg = 6'b111000;
			5'd8: six_neg = 6'b111001;
			5'd9: six_neg = 6'b100101;
			5'd10: six_neg = 6'b010101;
			5'd11: six_neg = 6'b110100;
			5'd12: six_neg = 6'b001101;
			5'd13: six_neg = 6'b101100;
			5'd14: six_neg = 6'b011100;
			5'd15: six_neg = 6'b010111;
			5'd16: six_neg = 6'b011011;
			5'd17: six_neg = 6'b100011;
			5'd18: six_neg = 6'b010011;
			5'd19: six_neg = 6'b110010;
			5'd20: six_neg = 6'b001011;
			5'd21: six_neg = 6'b101010;
			5'd22: six_neg = 6'b011010;
			5'd23: six_neg = 6'b111010;
			5'd24: six_neg = 6'b110011;
			5'd25: six_neg = 6'b100110;
			5'd26: six_neg = 6'b010110;
			5'd27: six_neg = 6'b110110;
			5'd28: six_neg = ctrl ? 6'b001111 : 6'b001110;
			5'd29: six_neg = 6'b101110;
			5'd30: six_neg = 6'b011110;
			default: six_neg = 6'b101011;
		endcase
		case (y)
			3'd0: four_neg = 4'b1011;
			3'd1: four_neg = 4'b1001;
			3'd2: four_neg = 4'b0101;
			3'd3: four_neg = 4'b1100;
			3'd4: four_neg = 4'b1101;
			3'd5: four_neg = 4'b1010;
			3'd6: four_neg = 4'b0110;
			default: four_neg = 4'b1110;
		endcase
		unbal6 = (six_neg != 6'b111000) && ((six_neg[5] + six_neg[4] + six_neg[3] +
			six_neg[2] + six_neg[1] + six_neg[0]) != 3'd3);
		// D.7 flips with disparity although balanced
		six = (rd_in && (unbal6 || x == 5'd7)) ? ~six_neg : six_neg;
		rd6 = unbal6 ? ~rd_in : rd_in;
		alt7 = (y == 3'd7) && (ctrl || (!rd6 && (x == 5'd17 || x == 5'd18 || x == 5'd20)) ||
			(rd6 && (x == 5'd11 || x == 5'd13 || x == 5'd14)));
		if (ctrl) begin
			// Only K28.5 and K28.7 are ever requested here
			four = (y == 3'd7) ? 4'b1000 : four_neg;
			four = rd6 ? four : ~four;
		end else if (alt7)
			four = rd6 ? 4'b1000 : 4'b0111;
		else if (rd6 && (y == 3'd0 || y == 3'd3 || y == 3'd4 || y == 3'd7))
			four = ~four_neg;
		else
			four = four_neg;
	end

	assign code = {six, four};
	assign rd_out = (four == 4'b1000 || four == 4'b0111 || four == 4'b1011 || four == 4'b0100 ||
		four == 4'b1101 || four == 4'b0010 || four == 4'b1110 || four == 4'b0001) ? ~rd6 : rd6;
endmodule // code_group_encoder
`default_nettype wire

// ### core/serial_adc_frame_transmitter.v
// Serial frame transmitter: format, dither removal, scrambling, 8b/10b framing, sync
// Notes on behaviour
// - Format select low gives offset binary; high gives two's complement samples.
// - Only both power-down inputs together stop conversion and the serial interface.
// - Dither from long pseudo-random sequence; same value subtracted from conversion result.
// - Each sample split into octets, each encoded into a 10-bit code group under running disparity.
// - One sample per frame; upper byte first, lower byte second; both optionally scrambled.
// - Code groups sent in order, bit 9 of first code group first.
// - Sync request held over more than one sample clock starts preamble.
// - Preamble is K28.5 commas, or idle sets K28.5 plus D5.6 or D16.2.
// - After request drops, finish preamble frame; data starts at next frame.
// - Scrambler 1+x^14+x^15, 16-bit parallel, one step per frame when enabled.
// - New sync request at any time resynchronises; sample data lost meanwhile.
// - Monitor off means no K28.7; on means K28.7 only in second group.
// - Monitor on, scrambler off: repeat of previous second group becomes K28.7, not twice.
// - Monitor and scrambler on: second group D28.7 sent as K28.7.
// - Rate range pins select PLL range: low, middle or high sample rate band.
`timescale 1ns/1ps
`default_nettype none
`include "serial_frame_defs.vh"
module serial_adc_frame_transmitter #(
	parameter SAMPLE_W = `SFT_SAMPLE_W,
	parameter FIFO_DEPTH = `SFT_FIFO_DEPTH,
	parameter FIFO_AW = 3
) (
	input wire clk,
	input wire reset_n,
	input wire [SAMPLE_W-1:0] conv_data,
	input wire conv_valid,
	output wire conv_ready,
	input wire sample_clock,
	input wire sync_request,
	input wire data_format_select,
	input wire [1:0] power_down_inputs,
	input wire preamble_type_select,
	input wire scrambler_enable,
	input wire alignment_monitor_enable,
	input wire dither_enable,
	input wire rate_range_select_low,
	input wire rate_range_select_high,
	output reg serial_out,
	output reg frame_start,
	output reg preamble_active,
	output reg power_down_active,
	output reg underrun,
	output reg [SAMPLE_W-1:0] dither_value,
	output reg [2:0] pll_range_sel
);
	// ********************************
	// States
	// ********************************
	localparam ST_OFF = 3'b001;
	localparam ST_DATA = 3'b010;
	localparam ST_PRE = 3'b100;

	// ********************************
	// Reset release and pin synchronisers
	// ********************************
	reg [1:0] rst_sync_q;
	wire rst_n;
	reg [9:0] pin_meta_q;
	reg [9:0] pin_q;
	reg sclk_prev_q;
	wire [9:0] pin_raw;
	wire sclk_s;
	wire sync_s;
	wire fmt_s;
	wire pd_s;
	wire idle_mode_s;
	wire scr_on_s;
	wire mon_on_s;
	wire dith_on_s;
	wire sclk_rise;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n)
			rst_sync_q <= 2'b00;
		else
			rst_sync_q <= {rst_sync_q[0], 1'b1};
	end
	assign rst_n = rst_sync_q[1];

	assign pin_raw = {rate_range_select_high, rate_range_select_low, dither_enable, alignment_monitor_enable,
		scrambler_enable, preamble_type_select, power_down_inputs[1] & power_down_inputs[0],
		data_format_select, sync_request, sample_clock};

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pin_meta_q <= 10'h000;
			pin_q <= 10'h000;
			sclk_prev_q <= 1'b0;
		end else begin
			pin_meta_q <= pin_raw;
			pin_q <= pin_meta_q;
			sclk_prev_q <= pin_q[0];
		end
	end

	assign sclk_s = pin_q[0];
	assign sync_s = pin_q[1];
	assign fmt_s = pin_q[2];
	assign pd_s = pin_q[3];
	assign idle_mode_s = pin_q[4];
	assign scr_on_s = pin_q[5];
	assign mon_on_s = pin_q[6];
	assign dith_on_s = pin_q[7];
	assign sclk_rise = sclk_s && !sclk_prev_q;

	// ********************************
	// Dither removal and sample format
	// ********************************
	reg [22:0] lfsr_q;
	wire accept;
	wire fifo_in_ready;
	wire [SAMPLE_W-1:0] corrected;
	wire [SAMPLE_W-1:0] formatted;

	assign accept = conv_valid && fifo_in_ready && !pd_s;
	assign conv_ready = fifo_in_ready;
	assign corrected = conv_data - dither_value;
	// Result is offset binary; inverting the top bit yields two's complement
	assign formatted = fmt_s ? {~corrected[SAMPLE_W-1], corrected[SAMPLE_W-2:0]} : corrected;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			lfsr_q <= `SFT_DITHER_SEED;
			dither_value <= {SAMPLE_W{1'b0}};
		end else if (!dith_on_s)
			dither_value <= {SAMPLE_W{1'b0}};
		else if (accept || dither_value == {SAMPLE_W{1'b0}}) begin
			// Step per accepted sample so each conversion gets its own value
			lfsr_q <= {lfsr_q[21:0], lfsr_q[22] ^ lfsr_q[17]};
			dither_value <= lfsr_q[SAMPLE_W-1:0];
		end
	end

	// ********************************
	// Sample buffer
	// ********************************
	wire fifo_out_valid;
	wire [SAMPLE_W-1:0] fifo_out_data;
	reg fifo_pop;

	sample_fifo #(
		.WIDTH(SAMPLE_W),
		.DEPTH(FIFO_DEPTH),
		.AW(FIFO_AW)
	) u_fifo (
		.clk(clk),
		.rst_n(rst_n),
		.in_valid(accept),
		.in_ready(fifo_in_ready),
		.in_data(formatted),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	// ********************************
	// Synchronisation request tracking
	// ********************************
	reg [1:0] req_cnt_q;
	wire pre_wanted;

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n)
			req_cnt_q <= 2'h0;
		else if (!sync_s)
			req_cnt_q <= 2'h0;
		else if (sclk_rise && req_cnt_q != `SFT_SYNC_EDGES)
			req_cnt_q <= req_cnt_q + 2'h1;
	end
	// Held across two sample clock edges means more than one cycle
	assign pre_wanted = sync_s && (req_cnt_q == `SFT_SYNC_EDGES);

	// ********************************
	// Frame builder
	// ********************************
	reg [2:0] state_q;
	reg [2:0] state_d;
	reg [3:0] bit_cnt_q;
	reg grp_q;
	reg [9:0] shift_q;
	reg rd_q;
	reg [14:0] scr_q;
	reg [7:0] b2_q;
	reg k2_q;
	reg idle2_q;
	reg [7:0] prev_b2_q;
	reg k287_prev_q;
	reg [SAMPLE_W-1:0] last_q;
	reg [SAMPLE_W-1:0] sample;
	reg [SAMPLE_W-1:0] scr_word;
	reg [14:0] scr_tmp;
	reg [7:0] code_byte;
	reg code_ctrl;
	reg [7:0] nb2;
	reg nk2;
	wire [9:0] code;
	wire rd_next;
	wire load;
	wire new_frame;
	integer i;

	assign load = (bit_cnt_q == `SFT_GROUP_BITS);
	assign new_frame = load && grp_q;

	// Parallel self-synchronising scrambler over the whole 16-bit frame
	always @* begin
		scr_tmp = scr_q;
		scr_word = {SAMPLE_W{1'b0}};
		sample = fifo_out_valid ? fifo_out_data : last_q;
		for (i = SAMPLE_W - 1; i >= 0; i = i - 1) begin
			scr_word[i] = sample[i] ^ scr_tmp[13] ^ scr_tmp[14];
			scr_tmp = {scr_tmp[13:0], scr_word[i]};
		end
		if (!scr_on_s)
			scr_word = sample;
	end

	always @* begin
		state_d = state_q;
		case (state_q)
			ST_OFF: if (!pd_s) state_d = ST_DATA;
			ST_DATA: if (pd_s) state_d = ST_OFF; else if (pre_wanted && new_frame) state_d = ST_PRE;
			// Return to data only on a frame boundary so the preamble frame completes; power down leaves at once
			ST_PRE: if (pd_s) state_d = ST_OFF; else if (!pre_wanted && new_frame) state_d = ST_DATA;
			default: state_d = ST_OFF;
		endcase
	end

	// Second group content of the frame about to start
	always @* begin
		nb2 = scr_word[7:0];
		nk2 = 1'b0;
		fifo_pop = 1'b0;
		if (new_frame && state_d == ST_DATA && state_q != ST_OFF)
			fifo_pop = fifo_out_valid;
		if (mon_on_s) begin
			if (scr_on_s)
				nk2 = (nb2 == `SFT_D28_7);
			else
				nk2 = (nb2 == prev_b2_q) && !k287_prev_q;
		end
	end

	// Encoder input: first group from new frame, second from stored copy
	always @* begin
		code_ctrl = 1'b0;
		code_byte = scr_word[15:8];
		if (new_frame) begin
			if (state_d == ST_PRE) begin
				code_byte = `SFT_K28_5;
				code_ctrl = 1'b1;
			end
		end else if (idle2_q)
			// Negative after the comma keeps it with D5.6, else D16.2 restores it
			code_byte = rd_q ? `SFT_D16_2 : `SFT_D5_6;
		else begin
			code_byte = b2_q;
			code_ctrl = k2_q;
		end
	end

	code_group_encoder u_coder (
		.data_byte(code_byte),
		.ctrl(code_ctrl),
		.rd_in(rd_q),
		.code(code),
		.rd_out(rd_next)
	);

	always @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state_q <= ST_OFF;
			bit_cnt_q <= `SFT_GROUP_BITS;
			grp_q <= 1'b1;
			shift_q <= 10'h000;
			rd_q <= 1'b0;
			scr_q <= `SFT_SCR_SEED;
			b2_q <= 8'h00;
			k2_q <= 1'b0;
			idle2_q <= 1'b0;
			prev_b2_q <= 8'h00;
			k287_prev_q <= 1'b0;
			last_q <= {SAMPLE_W{1'b0}};
			serial_out <= 1'b0;
			frame_start <= 1'b0;
			preamble_active <= 1'b0;
			power_down_active <= 1'b0;
			underrun <= 1'b0;
			pll_range_sel <= `SFT_RANGE_LOW;
		end else begin
			state_q <= state_d;
			power_down_active <= (state_d == ST_OFF);
			preamble_active <= (state_d == ST_PRE);
			frame_start <= 1'b0;
			underrun <= 1'b0;
			if (!pin_q[9])
				pll_range_sel <= `SFT_RANGE_LOW;
			else if (!pin_q[8])
				pll_range_sel <= `SFT_RANGE_MID;
			else
				pll_range_sel <= `SFT_RANGE_HIGH;
			if (state_d == ST_OFF) begin
				// Link silent; restart cleanly on a frame boundary
				bit_cnt_q <= `SFT_GROUP_BITS;
				grp_q <= 1'b1;
				shift_q <= 10'h000;
				rd_q <= 1'b0;
				serial_out <= 1'b0;
			end else begin
				serial_out <= shift_q[9];
				if (load) begin
					bit_cnt_q <= 4'h0;
					grp_q <= ~grp_q;
					shift_q <= code;
					rd_q <= rd_next;
				end else begin
					bit_cnt_q <= bit_cnt_q + 4'h1;
					shift_q <= {shift_q[8:0], 1'b0};
				end
				if (new_frame) begin
					frame_start <= 1'b1;
					if (state_d == ST_PRE) begin
						b2_q <= `SFT_K28_5;
						k2_q <= !idle_mode_s;
						idle2_q <= idle_mode_s;
						k287_prev_q <= 1'b0;
					end else begin
						idle2_q <= 1'b0;
						// Marker goes out as the control code; the data byte stays for the repeat compare
						b2_q <= nk2 ? `SFT_K28_7 : nb2;
						k2_q <= nk2;
						prev_b2_q <= nb2;
						k287_prev_q <= nk2;
						underrun <= !fifo_out_valid;
						last_q <= sample;
						if (scr_on_s)
							scr_q <= scr_word[14:0];
					end
				end
			end
		end
	end
endmodule // serial_adc_frame_transmitter
`default_nettype wire

// ### core/README_none.v
`timescale 1ns/1ps

// ### test/frame_tx_properties.sv
// Port checker for the serial frame transmitter
`timescale 1ns/1ps
`default_nettype none
module frame_tx_checker #(
	parameter SAMPLE_W = 16
) (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic conv_valid,
	input wire logic conv_ready,
	input wire logic sample_clock,
	input wire logic sync_request,
	input wire logic [1:0] power_down_inputs,
	input wire logic dither_enable,
	input wire logic rate_range_select_low,
	input wire logic rate_range_select_high,
	input wire logic serial_out,
	input wire logic frame_start,
	input wire logic preamble_active,
	input wire logic power_down_active,
	input wire logic underrun,
	input wire logic [SAMPLE_W-1:0] dither_value,
	input wire logic [2:0] pll_range_sel
);
	// ****************
	// Helpers
	// ****************
	default clocking dcb @(posedge clk); endclocking
	default disable iff (!reset_n);
	logic sc_q;
	logic [1:0] sc_cnt_q;
	wire logic [2:0] want_range = !rate_range_select_high ? 3'h1 : (rate_range_select_low ? 3'h4 : 3'h2);
	// Raw count leads the design's synchronised copy, so a floor of two is safe
	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			sc_q <= 1'b0;
			sc_cnt_q <= 2'h0;
		end else begin
			sc_q <= sample_clock;
			if (!sync_request) sc_cnt_q <= 2'h0;
			else if (sample_clock && !sc_q && sc_cnt_q != 2'h3) sc_cnt_q <= sc_cnt_q + 2'h1;
		end
	end
	// ****************
	// Properties
	// ****************
	property p_pd_on; (power_down_inputs == 2'h3) [*8] |-> power_down_active; endproperty
	a_pd_on: assert property (p_pd_on) else $error("power down not entered");
	property p_pd_both; (power_down_inputs != 2'h3) [*8] |-> !power_down_active; endproperty
	a_pd_both: assert property (p_pd_both) else $error("power down on one pin");
	property p_pd_quiet; power_down_active [*3] |-> !serial_out; endproperty
	a_pd_quiet: assert property (p_pd_quiet) else $error("line active in power down");
	property p_range; $stable(want_range) [*8] |-> pll_range_sel == want_range; endproperty
	a_range: assert property (p_range) else $error("pll range mismatch");
	property p_period; frame_start && !power_down_active |-> ##20 (frame_start || power_down_active); endproperty
	a_period: assert property (p_period) else $error("frame period not 20");
	property p_gap; frame_start |=> !frame_start [*8]; endproperty
	a_gap: assert property (p_gap) else $error("frame start too soon");
	property p_pre_rise; $rose(preamble_active) |-> sc_cnt_q >= 2'h2; endproperty
	a_pre_rise: assert property (p_pre_rise) else $error("preamble without held request");
	property p_pre_fall; $fell(preamble_active) |-> power_down_active || !$past(sync_request, 3); endproperty
	a_pre_fall: assert property (p_pre_fall) else $error("preamble ended while requested");
	property p_dith_off; (!dither_enable) [*4] |-> dither_value == '0; endproperty
	a_dith_off: assert property (p_dith_off) else $error("dither value while off");
	property p_dith_step;
		conv_valid && conv_ready && dither_enable && $past(dither_enable, 4) && !power_down_active
			|=> dither_value != $past(dither_value);
	endproperty
	a_dith_step: assert property (p_dith_step) else $error("dither did not step");
	c_pre: cover property ($rose(preamble_active));
	c_under: cover property (underrun);
	c_pd: cover property ($rose(power_down_active));
endmodule // frame_tx_checker
bind serial_adc_frame_transmitter frame_tx_checker #(.SAMPLE_W(SAMPLE_W)) u_frame_tx_checker (
	.clk(clk), .reset_n(reset_n), .conv_valid(conv_valid), .conv_ready(conv_ready),
	.sample_clock(sample_clock), .sync_request(sync_request), .power_down_inputs(power_down_inputs),
	.dither_enable(dither_enable), .rate_range_select_low(rate_range_select_low),
	.rate_range_select_high(rate_range_select_high), .serial_out(serial_out), .frame_start(frame_start),
	.preamble_active(preamble_active), .power_down_active(power_down_active), .underrun(underrun),
	.dither_value(dither_value), .pll_range_sel(pll_range_sel));
`default_nettype wire

// ### test/link_receiver_model.sv
// Receiver model: frames the serial line and drives the sync request
`timescale 1ns/1ps
`default_nettype none
module link_receiver_model (
	input wire logic clk,
	input wire logic rx_bit,
	input wire logic frame_mark,
	input wire logic link_off,
	input wire logic want_sync,
	output logic sync_request,
	output logic [9:0] grp1,
	output logic [9:0] grp2,
	output logic [9:0] grp2_fixed,
	output int rx_frames,
	output int disp_errs
);
	logic mark_q = 1'b0;
	logic [19:0] sh;
	logic rd;
	int cnt = 20;
	int seen = 0;
	initial begin
		rx_frames = 0;
		disp_errs = 0;
		rd = 1'b0;
		sync_request = 1'b0;
	end
	task automatic walk(input logic [9:0] g);
		if ($countones(g) == 6 && !rd) rd = 1'b1;
		else if ($countones(g) == 4 && rd) rd = 1'b0;
		else if ($countones(g) != 5) disp_errs++;
	endtask
	// No clock is sent; the shared clk gives bit timing and the frame mark stands in for frame alignment
	always @(posedge clk) begin
		mark_q <= frame_mark;
		sh = {sh[18:0], rx_bit};
		// First bit of a frame is sampled one edge after the mark is seen
		cnt = mark_q ? 0 : (cnt < 20 ? cnt + 1 : cnt);
		if (link_off) rd = 1'b0;
		if (cnt == 19) begin
			walk(sh[19:10]);
			walk(sh[9:0]);
			if (sync_request && sh[19:10] inside {10'h0fa, 10'h305}) seen++;
			grp1 <= sh[19:10];
			grp2 <= sh[9:0];
			grp2_fixed <= (sh[9:0] inside {10'h0f8, 10'h307}) ? grp2_fixed : sh[9:0];
			rx_frames <= rx_frames + 1;
		end
	end
	// Drop only after four comma frames; a fresh request edge rearms it
	always @(negedge clk) begin
		if (!want_sync) seen = 0;
		sync_request <= want_sync && seen < 4;
	end
endmodule // link_receiver_model
`default_nettype wire

// ### test/test_serial_adc_frame_transmitter.sv
// Self-checking bench for the serial frame transmitter
`timescale 1ns/1ps
`default_nettype none
module test_serial_adc_frame_transmitter;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic [15:0] conv_data = 16'h0000;
	logic conv_valid = 1'b0;
	logic sample_clock = 1'b0;
	logic fmt = 1'b0;
	logic [1:0] pd = 2'h0;
	logic ist = 1'b0;
	logic scr = 1'b0;
	logic mon = 1'b0;
	logic dith = 1'b0;
	logic rlo = 1'b0;
	logic rhi = 1'b0;
	logic want_sync = 1'b0;
	logic [1:0] watch = 2'h0;
	logic saw_under = 1'b0;
	logic saw_full = 1'b0;
	logic [31:0] lfsr = 32'h1cc6;
	wire logic conv_ready, serial_out, frame_start, preamble_active, power_down_active, underrun, sync_request;
	wire logic [15:0] dither_value;
	wire logic [2:0] pll_range_sel;
	wire logic [9:0] grp1, grp2, grp2_fixed;
	int rx_frames, disp_errs;
	int bad_count = 0;
	int num_checks = 0;
	serial_adc_frame_transmitter u_serial_adc_frame_transmitter (.clk(clk), .reset_n(reset_n),
		.conv_data(conv_data), .conv_valid(conv_valid), .conv_ready(conv_ready), .sample_clock(sample_clock),
		.sync_request(sync_request), .data_format_select(fmt), .power_down_inputs(pd), .preamble_type_select(ist),
		.scrambler_enable(scr), .alignment_monitor_enable(mon), .dither_enable(dith), .rate_range_select_low(rlo),
		.rate_range_select_high(rhi), .serial_out(serial_out), .frame_start(frame_start),
		.preamble_active(preamble_active), .power_down_active(power_down_active), .underrun(underrun),
		.dither_value(dither_value), .pll_range_sel(pll_range_sel));
	link_receiver_model u_link_receiver_model (.clk(clk), .rx_bit(serial_out), .frame_mark(frame_start),
		.link_off(power_down_active), .want_sync(want_sync), .sync_request(sync_request), .grp1(grp1),
		.grp2(grp2), .grp2_fixed(grp2_fixed), .rx_frames(rx_frames), .disp_errs(disp_errs));
	// ****************
	// Helpers
	// ****************
	initial forever #12.5 clk = ~clk;
	initial forever begin
		repeat (10) @(negedge clk);
		sample_clock = ~sample_clock;
	end
	always @(posedge clk) begin
		if (underrun === 1'b1) saw_under <= 1'b1;
		if (conv_valid === 1'b1 && conv_ready === 1'b0) saw_full <= 1'b1;
	end
	function automatic logic [2:0] kind(input logic [9:0] g);
		case (g)
			10'h0fa, 10'h305: kind = 3'h1;
			10'h0f8, 10'h307: kind = 3'h2;
			10'h274, 10'h18b: kind = 3'h3;
			10'h272, 10'h18d: kind = 3'h4;
			10'h296, 10'h1b5, 10'h245: kind = 3'h5;
			default: kind = 3'h0;
		endcase
	endfunction
	function automatic logic [31:0] next_rand(input logic [31:0] s);
		next_rand = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", num_checks, bad_count);
		if (bad_count == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic push(input logic [15:0] d);
		int n;
		n = 0;
		@(negedge clk);
		conv_data = d;
		conv_valid = 1'b1;
		while (conv_ready !== 1'b1 && n < 400) begin
			@(negedge clk);
			n++;
		end
		@(negedge clk);
		conv_valid = 1'b0;
	endtask
	task automatic frames(input int n);
		int k;
		k = rx_frames + n;
		wait (rx_frames >= k);
		@(negedge clk);
	endtask
	task automatic wait_pre(input logic v);
		repeat (40) if (preamble_active !== v) frames(1);
	endtask
	always @(rx_frames) begin
		#1;
		if (watch[0]) check("g1 k28_7", 16'(kind(grp1) == 3'h2), 16'h0);
		if (watch[1]) check("g2 k28_7", 16'(kind(grp2) == 3'h2), 16'h0);
	end
	// Sequence needs a few thousand cycles; the limit leaves wide margin
	initial begin
		#1000000;
		bad_count++;
		wrap_up();
	end
	// ****************
	// Sequence
	// ****************
	initial begin
		int i;
		int acc;
		logic [19:0] prev;
		repeat (2) @(negedge clk);
		check("range in reset", 16'(pll_range_sel), 16'h1);
		reset_n = 1'b1;
		for (i = 0; i < 4; i++) begin
			{rhi, rlo} = 2'(i);
			repeat (10) @(negedge clk);
			check("pll range", 16'(pll_range_sel), i < 2 ? 16'h1 : (i == 2 ? 16'h2 : 16'h4));
		end
		want_sync = 1'b1;
		wait_pre(1'b1);
		check("preamble on", 16'(preamble_active), 16'h1);
		frames(2);
		check("comma g1", 16'(kind(grp1)), 16'h1);
		check("comma g2", 16'(kind(grp2)), 16'h1);
		wait_pre(1'b0);
		check("preamble off", 16'(preamble_active), 16'h0);
		watch = 2'h3;
		for (i = 0; i < 4; i++) begin
			fmt = i[0] ^ i[1];
			// Format pin is synchronised; let it settle before the word is taken
			repeat (3) @(negedge clk);
			push({i[1], 15'h0});
			frames(3);
			check("high group", 16'(kind(grp1)), i[0] ? 16'h4 : 16'h3);
			check("low group", 16'(kind(grp2)), 16'h3);
		end
		check("underrun seen", 16'(saw_under), 16'h1);
		watch = 2'h1;
		mon = 1'b1;
		frames(3);
		for (i = 0; i < 4; i++) begin
			acc = kind(grp2);
			frames(1);
			check("repeat marker", 16'(kind(grp2) == 3'h2), 16'(acc != 2));
			check("restored", 16'(kind(grp2_fixed)), 16'h3);
		end
		scr = 1'b1;
		dith = 1'b1;
		for (i = 0; i < 24; i++) begin
			lfsr = next_rand(lfsr);
			push(lfsr[15:0]);
		end
		check("fifo refused", 16'(saw_full), 16'h1);
		check("dither moves", 16'(dither_value != 16'h0), 16'h1);
		saw_under = 1'b0;
		frames(12);
		check("fifo drained", 16'(saw_under), 16'h1);
		prev = {grp1, grp2};
		frames(1);
		check("scrambled repeat", 16'({grp1, grp2} != prev), 16'h1);
		check("disparity", 16'(disp_errs), 16'h0);
		dith = 1'b0;
		repeat (8) @(negedge clk);
		check("dither off", dither_value, 16'h0);
		pd = 2'h1;
		repeat (8) @(negedge clk);
		check("half power down", 16'(power_down_active), 16'h0);
		pd = 2'h3;
		repeat (24) @(negedge clk);
		acc = rx_frames;
		repeat (60) @(negedge clk);
		check("power down", 16'(power_down_active), 16'h1);
		check("line low", 16'(serial_out), 16'h0);
		check("link quiet", 16'(rx_frames - acc), 16'h0);
		pd = 2'h0;
		ist = 1'b1;
		want_sync = 1'b0;
		frames(3);
		want_sync = 1'b1;
		wait_pre(1'b1);
		frames(2);
		check("idle g1", 16'(kind(grp1)), 16'h1);
		check("idle g2", 16'(kind(grp2)), 16'h5);
		wait_pre(1'b0);
		frames(2);
		check("data back", 16'(preamble_active), 16'h0);
		wrap_up();
	end
endmodule // test_serial_adc_frame_transmitter
`default_nettype wire
